//--- eac_pkg.sv
/*
  Shared constants, types and helpers for the nonvolatile byte store access
  control block: register map, control field layout, reset values, timing
  counts and the request records passed between the control and engine.
  Assumes a single 10 MHz system clock and a 32-bit APB register bus.
*/
// Operation
// (RULE_01) Data register supplies the program byte and receives the byte read.
// (RULE_02) Mode 00 erase+write 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved.
// (RULE_03) Mode field writes are ignored while the program-start flag is set.
// (RULE_04) Reset clears the mode field to 00 unless programming is busy.
// (RULE_05) Ready interrupt reaches the core only with its enable and global enable.
// (RULE_06) Ready interrupt is a level, held while memory is idle and enabled.
// (RULE_07) Program starts only if start is set within four cycles of master enable.
// (RULE_08) Master enable clears itself four cycles after software sets it.
// (RULE_09) Program-start flag stays set until the programming time has elapsed.
// (RULE_10) The CPU is stalled two cycles after a program start.
// (RULE_11) Software sets the read strobe after loading the address.
// (RULE_12) A read completes at once; the byte is in the data register after.
// (RULE_13) The CPU is stalled four cycles after a read is triggered.
// (RULE_14) While programming, read strobes are refused and address writes blocked.
// (RULE_15) Software polls the program-start flag clear before reading.
// (RULE_16) Control bits 7 and 6 read zero; software writes them as zero.
// (RULE_17) Memory is addressed linearly by a nine-bit address in two byte registers.
// (RULE_18) A programming operation in progress finishes even across a reset.
// (RULE_19) A start with reserved mode 11 launches nothing and changes no memory.
package eac_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_DATA     = 8'h00;
    localparam logic [7:0] OFS_CTRL     = 8'h04;
    localparam logic [7:0] OFS_ADDR_LO  = 8'h08;
    localparam logic [7:0] OFS_ADDR_HI  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;

    // Control register field positions
    localparam int unsigned CTRL_READ    = 0;
    localparam int unsigned CTRL_START   = 1;
    localparam int unsigned CTRL_MPE     = 2;
    localparam int unsigned CTRL_RIE     = 3;
    localparam int unsigned CTRL_MODE_LO = 4;
    localparam int unsigned CTRL_MODE_HI = 5;

    // Interrupt status bit positions
    localparam int unsigned IRQ_PROG_DONE = 0;
    localparam int unsigned IRQ_READ_DONE = 1;
    localparam int unsigned IRQ_REFUSED   = 2;
    localparam int unsigned IRQ_W         = 3;

    // Reset values
    localparam logic [7:0]       DATA_RST = 8'h00;
    localparam logic [8:0]       ADDR_RST = 9'h000;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;
    localparam logic [7:0]       ERASED   = 8'hff;

    // Timing
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int unsigned T_ATOMIC_NS    = 3_400_000;
    localparam int unsigned T_SPLIT_NS     = 1_800_000;
    localparam int unsigned ATOMIC_CYC     = T_ATOMIC_NS / CLK_PERIOD_NS;
    localparam int unsigned SPLIT_CYC      = T_SPLIT_NS / CLK_PERIOD_NS;
    localparam logic [2:0]  MPE_WINDOW_CYC = 3'h4;
    localparam logic [2:0]  PROG_STALL_CYC = 3'h2;
    localparam logic [2:0]  READ_STALL_CYC = 3'h4;

    typedef enum logic [1:0] {
        EAC_MODE_ATOMIC = 2'h0,
        EAC_MODE_ERASE  = 2'h1,
        EAC_MODE_WRITE  = 2'h2,
        EAC_MODE_RSVD   = 2'h3
    } eac_mode_t;

    localparam eac_mode_t MODE_RST = EAC_MODE_ATOMIC;

    typedef struct packed {
        eac_mode_t  mode;
        logic [8:0] addr;
        logic [7:0] data;
    } eac_prog_req_t;

    typedef struct packed {
        logic          valid;
        eac_prog_req_t req;
    } eac_commit_t;

    // Reserved mode must never reach the array
    function automatic logic eac_mode_ok(input eac_mode_t m);
        return m != EAC_MODE_RSVD;
    endfunction : eac_mode_ok

endpackage : eac_pkg

//--- eac_prog_engine.sv
/*
  Programming engine: holds the busy flag and times one erase, write or
  atomic operation, then commits it to the array.
  Assumes its reset is the power-on reset only, so system reset cannot cut
  an operation short.
*/
`timescale 1ns/10ps
module eac_prog_engine #(
    parameter int unsigned ATOMIC_CYCLES = eac_pkg::ATOMIC_CYC,
    parameter int unsigned SPLIT_CYCLES  = eac_pkg::SPLIT_CYC
) (
    input  wire logic                   pclk,
    input  wire logic                   por_n,
    input  wire logic                   start,
    input  wire eac_pkg::eac_prog_req_t req,
    output logic                        busy,
    output eac_pkg::eac_commit_t        commit
);
    localparam int unsigned CW = $clog2(ATOMIC_CYCLES + 1);

    typedef enum logic [1:0] {
        EAC_ENG_IDLE = 2'b01,
        EAC_ENG_BUSY = 2'b10
    } eac_eng_state_t;

    eac_eng_state_t        state;
    logic [CW-1:0]         remain;
    eac_pkg::eac_prog_req_t held;

    // Only the power-on reset touches this, so work survives system reset
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            state  <= EAC_ENG_IDLE;
            remain <= '0;
            held   <= '0;
            commit <= '0;
        end else begin
            commit <= '0;
            case (state)
                EAC_ENG_IDLE: begin
                    if (start && eac_pkg::eac_mode_ok(req.mode)) begin // RULE_19
                        held  <= req;
                        state <= EAC_ENG_BUSY;
                        if (req.mode == eac_pkg::EAC_MODE_ATOMIC) begin // RULE_02
                            remain <= CW'(ATOMIC_CYCLES - 1);
                        end else begin
                            remain <= CW'(SPLIT_CYCLES - 1);
                        end
                    end
                end
                EAC_ENG_BUSY: begin
                    if (remain == '0) begin // RULE_09
                        commit <= '{valid: 1'b1, req: held};
                        state  <= EAC_ENG_IDLE;
                    end else begin
                        remain <= remain - 1'b1;
                    end
                end
                default: state <= EAC_ENG_IDLE;
            endcase
        end
    end

    assign busy = (state == EAC_ENG_BUSY); // RULE_18

endmodule : eac_prog_engine

//--- eac_nvm_array.sv
/*
  Byte array standing for the nonvolatile store, with a combinational read
  port and an erase/write commit port.
  Assumes commits come only from the programming engine.
*/
`timescale 1ns/10ps
module eac_nvm_array #(
    parameter int unsigned DEPTH = 512
) (
    input  wire logic                 pclk,
    input  wire eac_pkg::eac_commit_t commit,
    input  wire logic [8:0]           rd_addr,
    output logic [7:0]                rd_data
);
    logic [7:0] mem [DEPTH];

    // Write only can clear bits, never set them: unerased data is lost
    always_ff @(posedge pclk) begin
        if (commit.valid) begin
            case (commit.req.mode)
                eac_pkg::EAC_MODE_ATOMIC: mem[commit.req.addr] <= commit.req.data;
                eac_pkg::EAC_MODE_ERASE:  mem[commit.req.addr] <= eac_pkg::ERASED;
                eac_pkg::EAC_MODE_WRITE:
                    mem[commit.req.addr] <= mem[commit.req.addr] & commit.req.data;
                default: ;
            endcase
        end
    end

    assign rd_data = mem[rd_addr]; // RULE_17

endmodule : eac_nvm_array

//--- eac_control.sv
/*
  Top of the access control: APB register slave, two-step program guard,
  read strobe, CPU stall output, sticky event flags and the interrupt.
  Assumes an APB master on pclk, the core's global interrupt enable as a
  synchronous input, and a power-on reset separate from the system reset.
*/
`timescale 1ns/10ps
module eac_control #(
    parameter int unsigned ATOMIC_CYCLES = eac_pkg::ATOMIC_CYC,
    parameter int unsigned SPLIT_CYCLES  = eac_pkg::SPLIT_CYC,
    parameter int unsigned DEPTH         = 512
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        por_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        core_irq_global,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             cpu_stall
);

    // Software-visible state
    logic [7:0]               nv_data_byte;
    logic [8:0]               nv_address;
    eac_pkg::eac_mode_t       prog_mode_field;
    logic                     ready_irq_enable;
    logic                     master_prog_enable;
    logic [2:0]               mpe_left;
    logic                     read_strobe;
    logic [eac_pkg::IRQ_W-1:0] irq_status;
    logic [eac_pkg::IRQ_W-1:0] irq_enable;
    logic [2:0]               stall_left;

    // Engine and array wiring
    logic                     prog_start_flag;
    eac_pkg::eac_commit_t     commit;
    eac_pkg::eac_prog_req_t   prog_req;
    logic [7:0]               array_byte;

    // Decoded bus strobes
    logic                     setup;
    logic                     wr;
    logic                     wr_ctrl;
    logic [7:0]               wbyte;
    logic                     start_req;
    logic                     start_ok;
    logic                     read_req;
    logic                     read_ok;
    logic [eac_pkg::IRQ_W-1:0] irq_set;
    logic [eac_pkg::IRQ_W-1:0] irq_clr;
    logic [7:0]               rd_mux;
    logic                     rd_hit;
    logic [2:0]               next_stall;

    // Bus phase decode; only lane 0 carries register data
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pready & pwrite & pstrb[0];
    assign wbyte   = pwdata[7:0];
    assign wr_ctrl = wr && (paddr == eac_pkg::OFS_CTRL);

    // Start needs the guard still open and no operation running
    assign start_req = wr_ctrl && wbyte[eac_pkg::CTRL_START];
    assign start_ok  = start_req && master_prog_enable && !prog_start_flag // RULE_07
                       && eac_pkg::eac_mode_ok(prog_mode_field); // RULE_19
    assign read_req  = wr_ctrl && wbyte[eac_pkg::CTRL_READ]; // RULE_11
    assign read_ok   = read_req && !prog_start_flag; // RULE_14

    // Request handed to the engine; it latches these on start
    assign prog_req = '{mode: prog_mode_field, addr: nv_address, data: nv_data_byte}; // RULE_01

    eac_prog_engine #(
        .ATOMIC_CYCLES (ATOMIC_CYCLES),
        .SPLIT_CYCLES  (SPLIT_CYCLES)
    ) u_engine (
        .pclk   (pclk),
        .por_n  (por_n),
        .start  (start_ok),
        .req    (prog_req),
        .busy   (prog_start_flag),
        .commit (commit)
    );

    eac_nvm_array #(
        .DEPTH (DEPTH)
    ) u_array (
        .pclk    (pclk),
        .commit  (commit),
        .rd_addr (nv_address),
        .rd_data (array_byte)
    );

    // Read mux; reserved control and address bits read zero
    always_comb begin
        rd_mux = 8'h00;
        rd_hit = 1'b1;
        case (paddr)
            eac_pkg::OFS_DATA:     rd_mux = nv_data_byte;
            eac_pkg::OFS_CTRL: begin
                rd_mux = 8'h00; // RULE_16
                rd_mux[eac_pkg::CTRL_MODE_HI:eac_pkg::CTRL_MODE_LO] = prog_mode_field;
                rd_mux[eac_pkg::CTRL_RIE]   = ready_irq_enable;
                rd_mux[eac_pkg::CTRL_MPE]   = master_prog_enable;
                rd_mux[eac_pkg::CTRL_START] = prog_start_flag;
                rd_mux[eac_pkg::CTRL_READ]  = read_strobe;
            end
            eac_pkg::OFS_ADDR_LO:  rd_mux = nv_address[7:0];
            eac_pkg::OFS_ADDR_HI:  rd_mux = {7'h00, nv_address[8]};
            eac_pkg::OFS_IRQ_STAT: rd_mux = {5'h00, irq_status};
            eac_pkg::OFS_IRQ_EN:   rd_mux = {5'h00, irq_enable};
            eac_pkg::OFS_IRQ_CLR:  rd_mux = 8'h00;
            default:               rd_hit = 1'b0;
        endcase
    end

    // Fixed one wait-free access phase; answer registered from setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~rd_hit;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_mux};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Data byte: software writes it, a read loads it from the array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_data_byte <= eac_pkg::DATA_RST;
        end else if (read_ok) begin
            nv_data_byte <= array_byte; // RULE_12
        end else if (wr && paddr == eac_pkg::OFS_DATA) begin
            nv_data_byte <= wbyte; // RULE_01
        end
    end

    // Address is frozen while programming so the engine's copy stays true
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_address <= eac_pkg::ADDR_RST;
        end else if (wr && !prog_start_flag) begin // RULE_14
            if (paddr == eac_pkg::OFS_ADDR_LO) begin
                nv_address[7:0] <= wbyte; // RULE_17
            end else if (paddr == eac_pkg::OFS_ADDR_HI) begin
                nv_address[8] <= wbyte[0]; // RULE_17
            end
        end
    end

    // Mode field lives on the power-on reset; system reset is sampled here
    // so that a busy operation keeps its mode through it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            prog_mode_field <= eac_pkg::MODE_RST;
        end else if (!presetn) begin
            if (!prog_start_flag) begin
                prog_mode_field <= eac_pkg::MODE_RST; // RULE_04
            end
        end else if (wr_ctrl && !prog_start_flag) begin // RULE_03
            prog_mode_field <= eac_pkg::eac_mode_t'(
                wbyte[eac_pkg::CTRL_MODE_HI:eac_pkg::CTRL_MODE_LO]);
        end
    end

    // Ready interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable <= wbyte[eac_pkg::CTRL_RIE]; // RULE_05
        end
    end

    // Master enable: open for four cycles from the write, then self-clears.
    // Writing a zero does not close an open window early.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_prog_enable <= 1'b0;
            mpe_left           <= 3'h0;
        end else if (wr_ctrl && wbyte[eac_pkg::CTRL_MPE]) begin
            master_prog_enable <= 1'b1;
            mpe_left           <= eac_pkg::MPE_WINDOW_CYC - 3'h1; // RULE_08
        end else if (mpe_left != 3'h0) begin
            mpe_left <= mpe_left - 3'h1;
        end else begin
            master_prog_enable <= 1'b0; // RULE_08
        end
    end

    // Read strobe reads back one only in the cycle after it is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_strobe <= 1'b0;
        end else begin
            read_strobe <= read_ok;
        end
    end

    // Stall countdown; a new trigger reloads it
    always_comb begin
        if (start_ok) begin
            next_stall = eac_pkg::PROG_STALL_CYC; // RULE_10
        end else if (read_ok) begin
            next_stall = eac_pkg::READ_STALL_CYC; // RULE_13
        end else if (stall_left != 3'h0) begin
            next_stall = stall_left - 3'h1;
        end else begin
            next_stall = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_left <= 3'h0;
            cpu_stall  <= 1'b0;
        end else begin
            stall_left <= next_stall;
            cpu_stall  <= next_stall != 3'h0;
        end
    end

    // Event sources for the sticky flags
    always_comb begin
        irq_set = '0;
        irq_set[eac_pkg::IRQ_PROG_DONE] = commit.valid;
        irq_set[eac_pkg::IRQ_READ_DONE] = read_ok;
        irq_set[eac_pkg::IRQ_REFUSED]   = (start_req && !start_ok)
                                          || (read_req && !read_ok);
        irq_clr = '0;
        if (wr && paddr == eac_pkg::OFS_IRQ_CLR) begin
            irq_clr = wbyte[eac_pkg::IRQ_W-1:0];
        end
    end

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= eac_pkg::IRQ_RST;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= eac_pkg::IRQ_RST;
        end else if (wr && paddr == eac_pkg::OFS_IRQ_EN) begin
            irq_enable <= wbyte[eac_pkg::IRQ_W-1:0];
        end
    end

    // Ready level holds while idle; both sources need the global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= core_irq_global // RULE_05
                   && ((ready_irq_enable && !prog_start_flag) // RULE_06
                       || |(irq_status & irq_enable));
        end
    end

endmodule : eac_control

//--- eac_core_model.sv
/*
  Core-side partner: passes the global interrupt enable and measures
  the length of each stall burst. Assumes levels on pclk.
*/
`timescale 1ns/10ps
module eac_core_model (
    input  wire logic rst_n,
    input  wire logic pclk,
    input  wire logic gie,
    input  wire logic cpu_stall,
    output logic      core_irq_global,
    output logic [3:0] last_stall
);
    logic [3:0] run;

    // The core's own enable flag, no delay added
    assign core_irq_global = gie;

    // Burst length is kept until the next burst ends, so it can be read late
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            run        <= 4'h0;
            last_stall <= 4'h0;
        end else if (cpu_stall) begin
            run <= run + 4'h1;
        end else if (run != 4'h0) begin
            last_stall <= run;
            run        <= 4'h0;
        end
    end
endmodule : eac_core_model

//--- eac_control_chk.sv
/*
  Port checker: bus answer, reserved bits, interrupt gate, stall lengths.
  Assumes it is bound to eac_control on one pclk domain.
*/
`timescale 1ns/10ps
module eac_control_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        por_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        core_irq_global,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        cpu_stall
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    // Start of a stall burst
    sequence s_stall_go;
        !cpu_stall ##1 cpu_stall;
    endsequence

    a_setup_answer:
    assert property (s_setup |=> pready) else $error("setup not answered");
    a_pready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
    a_pready_cause:
    assert property (pready |-> $past(psel && !penable)) else $error("pready unasked");
    a_slverr_pair:
    assert property (pslverr |-> pready) else $error("pslverr alone");
    a_ctrl_res_zero:
    assert property (pready && !pwrite && paddr == eac_pkg::OFS_CTRL |-> prdata[31:6] == 26'h0)
        else $error("control top bits not zero");
    a_data_upper:
    assert property (pready && !pwrite && paddr == eac_pkg::OFS_DATA |-> prdata[31:8] == 24'h0)
        else $error("data upper bits not zero");
    a_irq_gate:
    assert property (!core_irq_global |=> !irq) else $error("irq without global");
    a_stall_min:
    assert property (s_stall_go |=> cpu_stall) else $error("stall too short");
    a_stall_max:
    assert property (s_stall_go |-> ##[1:4] !cpu_stall) else $error("stall too long");
endmodule : eac_control_chk

bind eac_control eac_control_chk i_chk (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .core_irq_global(core_irq_global), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .cpu_stall(cpu_stall)
);

//--- eac_control_bench.sv
/*
  Self-checking bench: APB tasks drive every mode, the enable window,
  busy refusals, reset mid-write and the interrupt. Assumes eac_pkg.
*/
`timescale 1ns/10ps
module eac_control_bench;
    logic        pclk, presetn, por_n, psel, penable, pwrite, gie, err;
    logic        pready, pslverr, irq, cpu_stall, core_irq_global;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, last_stall;
    int          num_errors, checked;
    logic [7:0]  dats [4] = '{8'h5a, 8'h00, 8'h0f, 8'h77};
    logic [7:0]  exps [4] = '{8'h5a, 8'hff, 8'h0f, 8'h0f};

    `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
        $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

    // Short counts keep each program wait to a few dozen cycles
    eac_control #(.ATOMIC_CYCLES(60), .SPLIT_CYCLES(30), .DEPTH(512)) i_dut (
        .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .core_irq_global(core_irq_global), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .cpu_stall(cpu_stall));
    eac_core_model i_core (.rst_n(presetn), .pclk(pclk), .gie(gie), .cpu_stall(cpu_stall),
        .core_irq_global(core_irq_global), .last_stall(last_stall));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // One transfer; an idle edge after it avoids re-driving psel in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (i == 15) begin num_errors++; summarize(); end
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd, err);
    endtask : wr

    task automatic chk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] x);
        xfer(1'b0, a, 32'h0, rd, err);
        `CHK(n, x, rd & m)
    endtask : chk

    // Wait for the program flag to drop, bounded
    task automatic poll();
        for (int i = 0; i < 100; i++) begin
            xfer(1'b0, eac_pkg::OFS_CTRL, 32'h0, rd, err);
            if (rd[1] === 1'b0) return;
        end
        num_errors++;
        summarize();
    endtask : poll

    // Data, then master enable, then start inside the window
    task automatic prog(input logic [1:0] m, input logic [7:0] d, input logic r);
        wr(eac_pkg::OFS_DATA, {24'h0, d});
        wr(eac_pkg::OFS_CTRL, {26'h0, m, r, 3'h4});
        wr(eac_pkg::OFS_CTRL, {26'h0, m, r, 3'h2});
    endtask : prog

    task automatic rdb(input logic [7:0] x);
        wr(eac_pkg::OFS_CTRL, 32'h1);
        chk("read byte", eac_pkg::OFS_DATA, 32'hffffffff, {24'h0, x});
        repeat (3) @(posedge pclk);
        `CHK("read stall", 4'h4, last_stall)
    endtask : rdb

    initial begin
        presetn = 1'b0;
        por_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        gie = 1'b0;
        num_errors = 0;
        checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        @(posedge pclk);
        chk("data rst", eac_pkg::OFS_DATA, 32'hffffffff, 32'h0);
        chk("ctrl rst", eac_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
        xfer(1'b0, 8'h40, 32'h0, rd, err);
        `CHK("unmapped", 1'b1, err)
        // Lane 0 strobe low must leave the data byte alone
        pstrb <= 4'he;
        wr(eac_pkg::OFS_DATA, 32'h99);
        pstrb <= 4'hf;
        chk("strb off", eac_pkg::OFS_DATA, 32'hffffffff, 32'h0);
        wr(eac_pkg::OFS_ADDR_LO, 32'h34);
        wr(eac_pkg::OFS_ADDR_HI, 32'h1);
        chk("addr hi", eac_pkg::OFS_ADDR_HI, 32'hffffffff, 32'h1);
        // Every mode at one byte; reserved must leave it alone
        for (int i = 0; i < 4; i++) begin
            prog(i[1:0], dats[i], 1'b0);
            if (i < 3) begin
                // Flag must still stand just before the count runs out, then drop
                repeat ((i == 0) ? 56 : 26) @(posedge pclk);
                chk("prog busy", eac_pkg::OFS_CTRL, 32'h2, 32'h2);
                chk("prog time", eac_pkg::OFS_CTRL, 32'h2, 32'h0);
            end
            poll();
            if (i < 3) `CHK("prog stall", 4'h2, last_stall)
            rdb(exps[i]);
        end
        // Window open for four cycles, then shut; a late start is refused
        wr(eac_pkg::OFS_IRQ_CLR, 32'h7);
        wr(eac_pkg::OFS_CTRL, 32'h4);
        chk("mpe open", eac_pkg::OFS_CTRL, 32'h4, 32'h4);
        chk("mpe shut", eac_pkg::OFS_CTRL, 32'h4, 32'h0);
        wr(eac_pkg::OFS_CTRL, 32'h2);
        chk("late start", eac_pkg::OFS_CTRL, 32'h2, 32'h0);
        chk("refused", eac_pkg::OFS_IRQ_STAT, 32'h7, 32'h4);
        // While erasing, mode, address and read are shut out
        prog(2'h1, 8'h00, 1'b0);
        wr(eac_pkg::OFS_CTRL, 32'h21);
        wr(eac_pkg::OFS_ADDR_LO, 32'h00);
        chk("mode kept", eac_pkg::OFS_CTRL, 32'h33, 32'h12);
        chk("addr kept", eac_pkg::OFS_ADDR_LO, 32'hff, 32'h34);
        poll();
        // System reset mid-write: the write runs on, the mode survives
        prog(2'h2, 8'h00, 1'b0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("mode held", eac_pkg::OFS_CTRL, 32'h32, 32'h22);
        poll();
        wr(eac_pkg::OFS_ADDR_LO, 32'h34);
        wr(eac_pkg::OFS_ADDR_HI, 32'h1);
        rdb(8'h00);
        // Done flag through enable and global gate, then the ready level
        wr(eac_pkg::OFS_IRQ_CLR, 32'h7);
        wr(eac_pkg::OFS_IRQ_EN, 32'h1);
        prog(2'h1, 8'h00, 1'b0);
        poll();
        gie <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("irq done", 1'b1, irq)
        gie <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("irq gated", 1'b0, irq)
        gie <= 1'b1;
        wr(eac_pkg::OFS_IRQ_CLR, 32'h1);
        chk("stat clr", eac_pkg::OFS_IRQ_STAT, 32'h1, 32'h0);
        `CHK("irq clr", 1'b0, irq)
        wr(eac_pkg::OFS_CTRL, 32'h8);
        repeat (3) @(posedge pclk);
        `CHK("irq ready", 1'b1, irq)
        prog(2'h1, 8'h00, 1'b1);
        repeat (2) @(posedge pclk);
        `CHK("irq busy", 1'b0, irq)
        poll();
        summarize();
    end
endmodule : eac_control_bench
